// *** rtl/scx_consts.svh ***
// register offsets, field positions, reset values and timings in ns
`ifndef SCX_CONSTS_SVH
`define SCX_CONSTS_SVH

`define SCX_ADR_MODE 8'h00
`define SCX_ADR_CTRL 8'h04
`define SCX_ADR_TXBUF 8'h08
`define SCX_ADR_RXBUF 8'h0c
`define SCX_ADR_FLAGS 8'h10
`define SCX_ADR_IRQ_STAT 8'h14
`define SCX_ADR_IRQ_CLR 8'h18
`define SCX_ADR_IRQ_EN 8'h1c
`define SCX_ADR_PORT 8'h20
`define SCX_ADR_POWER 8'h24
`define SCX_ADR_I2C_MODE 8'h28

`define SCX_B_SYNC_MODE 0
`define SCX_B_I2C_SEL 0
`define SCX_B_TX_ON 0
`define SCX_B_RX_ON 1
`define SCX_B_PIN_SER 0
`define SCX_B_GP_LVL 1
`define SCX_B_GP_DIR 2
`define SCX_B_STOP 0

`define SCX_TRANSMIT_END_FLAG_RST 1'b1
`define SCX_PIN_RST 3'h5

`define SCX_CLK_NS 10
`define SCX_BIT_NS 8680

`endif

// *** rtl/scx_pkg.sv ***
// types shared by the serial control block
package scx_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} scx_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scx_rx_st_t;

  typedef struct packed {
    logic tx_done;
    logic rx_full;
    logic tx_empty;
  } scx_irq_t;

  typedef struct packed {
    logic cs;
    logic sck;
    logic rx;
  } scx_pins_t;

  typedef struct packed {
    scx_pins_t m1;
    scx_pins_t m2;
    scx_pins_t m3;
  } scx_sync_st_t;

  typedef struct packed {
    logic sync_clock_mode_sel;
    logic i2c_simple_sel;
    logic tx_on;
    logic rx_on;
    logic [7:0] tx_buffer_reg;
    logic tx_buf_full;
    logic [7:0] tx_shift_reg;
    logic transmit_end_flag;
    logic [7:0] rx_buf;
    logic rx_buf_full;
    logic [7:0] rx_shift;
    scx_irq_t irq_st;
    scx_irq_t irq_en;
    logic pin_ser;
    logic gp_lvl;
    logic gp_dir;
    logic stop;
    scx_tx_st_t tx_st;
    scx_rx_st_t rx_st;
    logic [15:0] tx_cnt;
    logic [15:0] rx_cnt;
    logic [2:0] tx_bit;
    logic [2:0] rx_bit;
    logic [2:0] s_bits;
    logic tx_line;
    logic [31:0] rdata;
    logic irq;
    logic txd_o;
    logic txd_oe;
    logic miso_o;
    logic miso_oe;
  } scx_state_t;

endpackage

// *** rtl/scx_sync.sv ***
// two-flop synchronisers and edge finders for the link pins
`timescale 1ns/1ns
`include "scx_consts.svh"
module scx_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // raw pins and clean results
  input wire scx_pkg::scx_pins_t pins_raw,
  output scx_pkg::scx_pins_t lvl,
  output scx_pkg::scx_pins_t rise,
  output scx_pkg::scx_pins_t fall
);

  scx_pkg::scx_sync_st_t st_q;
  scx_pkg::scx_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.m1 = pins_raw;
    st_d.m2 = st_q.m1;
    st_d.m3 = st_q.m2;
  end

  // idle levels at reset: receive and select high, clock low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= {3{`SCX_PIN_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // only the second and third stages are looked at
  assign lvl = st_q.m2;
  assign rise = st_q.m2 & ~st_q.m3;
  assign fall = ~st_q.m2 & st_q.m3;

endmodule

// *** rtl/scx_top.sv ***
// serial control block: enables, transmit end, break, slave select, stop
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "scx_consts.svh"
module scx_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // interrupt
  output logic IRQ_OUT,
  // link pins
  input wire logic SERIAL_IN_PIN,
  input wire logic SERIAL_CLK_IN,
  input wire logic CHIP_SEL_IN_B,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE,
  output logic SLAVE_OUT_LINE_O,
  output logic SLAVE_OUT_LINE_OE
);

  localparam int BIT_CYC = (`SCX_BIT_NS + `SCX_CLK_NS - 1) / `SCX_CLK_NS;
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYC / 2 - 1);

  scx_pkg::scx_state_t st_q;
  scx_pkg::scx_state_t st_d;
  scx_pkg::scx_pins_t pin_lvl;
  scx_pkg::scx_pins_t pin_rise;
  scx_pkg::scx_pins_t pin_fall;
  scx_pkg::scx_irq_t ev;
  scx_pkg::scx_irq_t irq_clr;
  logic lock;
  logic wr_txbuf;
  logic wr_ctrl;
  logic act;
  logic sdone;
  logic ser;

  scx_sync u_sync (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pins_raw({CHIP_SEL_IN_B, SERIAL_CLK_IN, SERIAL_IN_PIN}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign lock = (st_q.sync_clock_mode_sel | st_q.i2c_simple_sel) &
                (st_q.tx_on | st_q.rx_on);
  assign wr_ctrl = REG_WR && (REG_ADDR == `SCX_ADR_CTRL);
  assign wr_txbuf = REG_WR && (REG_ADDR == `SCX_ADR_TXBUF) && st_q.tx_on;
  // a character already begun runs to its end even with select high
  assign act = st_q.sync_clock_mode_sel && !st_q.stop &&
               (st_q.tx_on || st_q.rx_on) &&
               (!pin_lvl.cs || st_q.s_bits != 3'h0);

  always_comb begin
    st_d = st_q;
    ev = '0;
    irq_clr = '0;
    sdone = 1'b0;
    ser = 1'b0;
    st_d.rdata = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        `SCX_ADR_MODE: st_d.rdata = 32'(st_q.sync_clock_mode_sel);
        `SCX_ADR_I2C_MODE: st_d.rdata = 32'(st_q.i2c_simple_sel);
        `SCX_ADR_CTRL: st_d.rdata = 32'({st_q.rx_on, st_q.tx_on});
        `SCX_ADR_RXBUF: begin
          st_d.rdata = 32'(st_q.rx_buf);
          st_d.rx_buf_full = 1'b0;
        end
        `SCX_ADR_FLAGS: st_d.rdata = 32'({st_q.rx_buf_full,
                                          ~st_q.tx_buf_full,
                                          st_q.transmit_end_flag});
        `SCX_ADR_IRQ_STAT: st_d.rdata = 32'(st_q.irq_st);
        `SCX_ADR_IRQ_EN: st_d.rdata = 32'(st_q.irq_en);
        `SCX_ADR_PORT: st_d.rdata = 32'({st_q.gp_dir, st_q.gp_lvl,
                                         st_q.pin_ser});
        `SCX_ADR_POWER: st_d.rdata = 32'(st_q.stop);
        default: st_d.rdata = '0;
      endcase
    end
    if (REG_WR) begin
      case (REG_ADDR)
        `SCX_ADR_MODE: begin
          st_d.sync_clock_mode_sel = REG_WDATA[`SCX_B_SYNC_MODE];
        end
        `SCX_ADR_I2C_MODE: begin
          st_d.i2c_simple_sel = REG_WDATA[`SCX_B_I2C_SEL];
        end
        `SCX_ADR_CTRL: begin
          if (lock) begin
            // only clearing is possible until both are 0 again
            st_d.tx_on = st_q.tx_on & REG_WDATA[`SCX_B_TX_ON];
            st_d.rx_on = st_q.rx_on & REG_WDATA[`SCX_B_RX_ON];
          end else begin
            // both 0 in restricted modes, or free in plain async mode
            st_d.tx_on = REG_WDATA[`SCX_B_TX_ON];
            st_d.rx_on = REG_WDATA[`SCX_B_RX_ON];
          end
        end
        `SCX_ADR_TXBUF: begin
          if (st_q.tx_on) begin
            st_d.tx_buffer_reg = REG_WDATA[7:0];
            st_d.tx_buf_full = 1'b1;
            st_d.transmit_end_flag = 1'b0;
          end
        end
        `SCX_ADR_IRQ_CLR: irq_clr = REG_WDATA[2:0];
        `SCX_ADR_IRQ_EN: st_d.irq_en = REG_WDATA[2:0];
        `SCX_ADR_PORT: begin
          st_d.pin_ser = REG_WDATA[`SCX_B_PIN_SER];
          st_d.gp_lvl = REG_WDATA[`SCX_B_GP_LVL];
          st_d.gp_dir = REG_WDATA[`SCX_B_GP_DIR];
        end
        `SCX_ADR_POWER: st_d.stop = REG_WDATA[`SCX_B_STOP];
        default: begin
        end
      endcase
    end

    // transmitter
    if (!st_d.tx_on || st_q.stop) begin
      // a cut character is dropped; the line goes back to mark
      st_d.tx_st = scx_pkg::TX_IDLE;
      st_d.tx_shift_reg = '0;
      st_d.tx_cnt = '0;
      st_d.tx_bit = '0;
      st_d.tx_line = 1'b1;
      if (!st_d.tx_on) begin
        st_d.transmit_end_flag = `SCX_TRANSMIT_END_FLAG_RST;
      end
    end else if (!st_q.sync_clock_mode_sel) begin
      case (st_q.tx_st)
        scx_pkg::TX_IDLE: begin
          st_d.tx_line = 1'b1;
          if (st_q.tx_buf_full) begin
            st_d.tx_shift_reg = st_q.tx_buffer_reg;
            st_d.tx_buf_full = wr_txbuf;
            st_d.transmit_end_flag = 1'b0;
            ev.tx_empty = 1'b1;
            st_d.tx_cnt = '0;
            st_d.tx_st = scx_pkg::TX_START;
          end
        end
        scx_pkg::TX_START: begin
          st_d.tx_line = 1'b0;
          st_d.tx_cnt = st_q.tx_cnt + 16'h1;
          if (st_q.tx_cnt == BIT_LAST) begin
            st_d.tx_cnt = '0;
            st_d.tx_bit = '0;
            st_d.tx_st = scx_pkg::TX_DATA;
          end
        end
        scx_pkg::TX_DATA: begin
          st_d.tx_line = st_q.tx_shift_reg[0];
          st_d.tx_cnt = st_q.tx_cnt + 16'h1;
          if (st_q.tx_cnt == BIT_LAST) begin
            st_d.tx_cnt = '0;
            st_d.tx_shift_reg = {1'b0, st_q.tx_shift_reg[7:1]};
            st_d.tx_bit = st_q.tx_bit + 3'h1;
            if (st_q.tx_bit == 3'h7) begin
              st_d.tx_st = scx_pkg::TX_STOP;
            end
          end
        end
        scx_pkg::TX_STOP: begin
          st_d.tx_line = 1'b1;
          st_d.tx_cnt = st_q.tx_cnt + 16'h1;
          if (st_q.tx_cnt == BIT_LAST) begin
            st_d.tx_cnt = '0;
            st_d.tx_st = scx_pkg::TX_IDLE;
            if (!st_q.tx_buf_full) begin
              st_d.transmit_end_flag = 1'b1;
              ev.tx_done = 1'b1;
            end
          end
        end
        default: st_d.tx_st = scx_pkg::TX_IDLE;
      endcase
    end else begin
      st_d.tx_line = 1'b1;
      // loading between characters only, so a frame never tears
      if (st_q.tx_st == scx_pkg::TX_IDLE && st_q.tx_buf_full &&
          st_q.s_bits == 3'h0) begin
        st_d.tx_shift_reg = st_q.tx_buffer_reg;
        st_d.tx_buf_full = wr_txbuf;
        st_d.transmit_end_flag = 1'b0;
        ev.tx_empty = 1'b1;
        st_d.tx_st = scx_pkg::TX_DATA;
      end
    end

    // asynchronous receiver, sampled mid-bit
    if (!st_d.rx_on || st_q.stop || st_q.sync_clock_mode_sel) begin
      st_d.rx_st = scx_pkg::RX_IDLE;
      st_d.rx_cnt = '0;
      st_d.rx_bit = '0;
    end else begin
      st_d.rx_cnt = st_q.rx_cnt + 16'h1;
      case (st_q.rx_st)
        scx_pkg::RX_IDLE: begin
          st_d.rx_cnt = '0;
          if (pin_fall.rx) begin
            st_d.rx_st = scx_pkg::RX_START;
          end
        end
        scx_pkg::RX_START: begin
          if (st_q.rx_cnt == HALF_LAST) begin
            st_d.rx_cnt = '0;
            st_d.rx_bit = '0;
            st_d.rx_st = pin_lvl.rx ? scx_pkg::RX_IDLE : scx_pkg::RX_DATA;
          end
        end
        scx_pkg::RX_DATA: begin
          if (st_q.rx_cnt == BIT_LAST) begin
            st_d.rx_cnt = '0;
            st_d.rx_shift = {pin_lvl.rx, st_q.rx_shift[7:1]};
            st_d.rx_bit = st_q.rx_bit + 3'h1;
            if (st_q.rx_bit == 3'h7) begin
              st_d.rx_st = scx_pkg::RX_STOP;
            end
          end
        end
        scx_pkg::RX_STOP: begin
          if (st_q.rx_cnt == BIT_LAST) begin
            st_d.rx_buf = st_q.rx_shift;
            st_d.rx_buf_full = 1'b1;
            ev.rx_full = 1'b1;
            st_d.rx_st = scx_pkg::RX_IDLE;
          end
        end
        default: st_d.rx_st = scx_pkg::RX_IDLE;
      endcase
    end

    // clocked slave: sample on rising, shift out on falling
    if (!act) begin
      if (st_q.stop || !st_q.sync_clock_mode_sel) begin
        st_d.s_bits = '0;
      end
    end else if (pin_rise.sck) begin
      st_d.rx_shift = {pin_lvl.rx, st_q.rx_shift[7:1]};
      st_d.s_bits = st_q.s_bits + 3'h1;
      if (st_q.s_bits == 3'h7) begin
        sdone = 1'b1;
        if (st_d.rx_on) begin
          st_d.rx_buf = {pin_lvl.rx, st_q.rx_shift[7:1]};
          st_d.rx_buf_full = 1'b1;
          ev.rx_full = 1'b1;
        end
        if (st_d.tx_on && st_q.tx_st == scx_pkg::TX_DATA) begin
          st_d.tx_st = scx_pkg::TX_IDLE;
          if (!st_q.tx_buf_full) begin
            st_d.transmit_end_flag = 1'b1;
            ev.tx_done = 1'b1;
          end
        end
      end
    end else if (pin_fall.sck && st_q.s_bits != 3'h0 && st_d.tx_on) begin
      st_d.tx_shift_reg = {1'b0, st_q.tx_shift_reg[7:1]};
    end

    // sticky status: an event in the clearing cycle survives
    st_d.irq_st = (st_q.irq_st & ~irq_clr) | ev;
    st_d.irq = |(st_d.irq_st & st_d.irq_en);

    // pin is the port's unless enabled, not stopped and handed to the serial function
    ser = st_d.pin_ser & st_d.tx_on & ~st_d.stop;
    st_d.txd_o = ser ? st_d.tx_line : st_d.gp_lvl;
    st_d.txd_oe = ser | st_d.gp_dir;
    st_d.miso_o = (st_d.stop || st_d.tx_st != scx_pkg::TX_DATA) ? 1'b1 :
                  st_d.tx_shift_reg[0];
    st_d.miso_oe = st_d.sync_clock_mode_sel & st_d.tx_on & ~st_d.stop &
                   ~pin_lvl.cs;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= '0;
      st_q.transmit_end_flag <= `SCX_TRANSMIT_END_FLAG_RST;
      st_q.tx_line <= 1'b1;
      st_q.miso_o <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;
  assign IRQ_OUT = st_q.irq;
  assign SERIAL_OUT_PIN_O = st_q.txd_o;
  assign SERIAL_OUT_PIN_OE = st_q.txd_oe;
  assign SLAVE_OUT_LINE_O = st_q.miso_o;
  assign SLAVE_OUT_LINE_OE = st_q.miso_oe;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  en_lock_a: assert property (
    wr_ctrl && lock && !st_q.tx_on |=> !st_q.tx_on)
    else $error("enable set while locked");

  en_first_a: assert property (
    wr_ctrl && !lock && st_q.sync_clock_mode_sel &&
    REG_WDATA[`SCX_B_TX_ON] |=> st_q.tx_on)
    else $error("first enable write lost");

  en_free_a: assert property (
    wr_ctrl && !st_q.sync_clock_mode_sel && !st_q.i2c_simple_sel |=>
    st_q.rx_on == $past(REG_WDATA[`SCX_B_RX_ON]))
    else $error("free enable write not taken");

  end_clr_a: assert property (
    wr_txbuf && !st_q.sync_clock_mode_sel && !st_q.stop &&
    st_q.tx_st == scx_pkg::TX_IDLE && !wr_ctrl
    |=> !st_q.transmit_end_flag [*2])
    else $error("end flag not cleared by data write");

  tx_off_a: assert property (
    $fell(st_q.tx_on) |-> st_q.tx_st == scx_pkg::TX_IDLE &&
    st_q.tx_shift_reg == 8'h00 && st_q.transmit_end_flag)
    else $error("transmitter not reset on disable");

  miso_float_a: assert property (
    st_q.sync_clock_mode_sel && pin_rise.cs |=> !SLAVE_OUT_LINE_OE)
    else $error("slave output still driven after select rise");

  cs_finish_a: assert property (
    act && pin_lvl.cs && pin_rise.sck |=>
    st_q.s_bits == $past(st_q.s_bits) + 3'h1)
    else $error("shifting stopped before character end");

  late_irq_a: assert property (
    sdone && st_d.rx_on && pin_lvl.cs |=> st_q.irq_st.rx_full)
    else $error("finished character raised no interrupt");

  pin_port_a: assert property (
    !st_q.tx_on |-> SERIAL_OUT_PIN_O == st_q.gp_lvl &&
    SERIAL_OUT_PIN_OE == st_q.gp_dir)
    else $error("output pin not following port");

  stop_high_a: assert property (
    $fell(st_q.stop) && st_q.tx_on && st_q.pin_ser |->
    SERIAL_OUT_PIN_O ##1 SERIAL_OUT_PIN_O)
    else $error("output not high after stop");

  cover_lock_c: cover property (wr_ctrl && lock);
  cover_cs_mid_c: cover property (sdone && pin_lvl.cs);
  cover_tx_done_c: cover property (ev.tx_done && !st_q.sync_clock_mode_sel);
  cover_irq_c: cover property ($rose(IRQ_OUT));

endmodule

// *** sim/scx_peer.sv ***
// behavioural far-end serial peer: async frames and clocked slave traffic
`timescale 1ns/1ns
`include "scx_consts.svh"
module scx_peer (
  // lines toward the device
  output logic rx_line,
  output logic sck_line,
  output logic cs_line_b,
  // line from the device
  input wire logic tx_line
);
  initial begin
    rx_line = 1'b1;
    sck_line = 1'b0;
    cs_line_b = 1'b1;
  end
  // slave select, driven only from here
  task automatic sel(input logic v);
    cs_line_b = v;
  endtask
  // start bit, eight bits lsb first, stop bit, then mark
  task automatic send_async(input logic [7:0] b);
    rx_line = 1'b0;
    #(`SCX_BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rx_line = b[i];
      #(`SCX_BIT_NS);
    end
    rx_line = 1'b1;
    #(`SCX_BIT_NS);
  endtask
  // samples mid-bit, timed from the start edge
  task automatic get_async(output logic [7:0] b);
    @(negedge tx_line);
    #(`SCX_BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_line;
      #(`SCX_BIT_NS);
    end
  endtask
  // clock stands still between calls, so a character may be cut in two
  task automatic clk_bits(input logic [7:0] b, input int first,
                          input int last);
    for (int i = first; i < last; i++) begin
      rx_line = b[i];
      #62 sck_line = 1'b1;
      #63 sck_line = 1'b0;
    end
    // released data line must not keep the last bit
    rx_line = ~rx_line;
  endtask
endmodule

// *** sim/scx_top_tb_top.sv ***
// self-checking bench for the serial control block
`timescale 1ns/1ns
`include "scx_consts.svh"
module scx_top_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq_out;
  logic rx_line, sck_line, cs_line_b;
  logic txd_o, txd_oe, miso_o, miso_oe;
  wire tx_wire = txd_oe ? txd_o : 1'b1;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] rnd = 8'h14;
  logic [31:0] d;
  logic [7:0] b, got;
  logic [1:0] w, ce;
  int n;
  logic [7:0] so;

  // master side of the slave line: only bits seen while it is driven
  always @(posedge sck_line) begin
    if (miso_oe) begin
      so <= {miso_o, so[7:1]};
    end
  end

  initial begin
    forever #5 clk = ~clk;
  end

  scx_top u_dut (
    .CLK_SYS(clk), .RST_B(rst_b),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .IRQ_OUT(irq_out),
    .SERIAL_IN_PIN(rx_line), .SERIAL_CLK_IN(sck_line),
    .CHIP_SEL_IN_B(cs_line_b),
    .SERIAL_OUT_PIN_O(txd_o), .SERIAL_OUT_PIN_OE(txd_oe),
    .SLAVE_OUT_LINE_O(miso_o), .SLAVE_OUT_LINE_OE(miso_oe)
  );

  scx_peer u_peer (
    .rx_line(rx_line), .sck_line(sck_line),
    .cs_line_b(cs_line_b), .tx_line(tx_wire)
  );

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // enable bits after a write: locked modes only let zeros through
  function automatic logic [1:0] ctrl_next(input logic [1:0] old,
      input logic [1:0] wv, input logic lock_mode);
    return (lock_mode && old != 2'h0) ? (old & wv) : wv;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(`SCX_ADR_FLAGS, d);
    chk(d[0], `SCX_TRANSMIT_END_FLAG_RST);
    rd(8'h30, d);
    chk(d, 32'h0);
    $display("test reset done");
    // none, clocked mode, i2c mode; random enable writes
    for (int s = 0; s < 3; s++) begin
      wr(`SCX_ADR_CTRL, 32'h0);
      wr(`SCX_ADR_MODE, {31'h0, s == 1});
      wr(`SCX_ADR_I2C_MODE, {31'h0, s == 2});
      ce = 2'h0;
      repeat (10) begin
        rnd = lfsr_next(rnd);
        w = rnd[1:0];
        wr(`SCX_ADR_CTRL, {30'h0, w});
        ce = ctrl_next(ce, w, s != 0);
        rd(`SCX_ADR_CTRL, d);
        chk(d[1:0], ce);
      end
    end
    wr(`SCX_ADR_CTRL, 32'h0);
    wr(`SCX_ADR_MODE, 32'h0);
    wr(`SCX_ADR_I2C_MODE, 32'h0);
    $display("test enables done");
    for (int k = 0; k < 8; k++) begin
      wr(`SCX_ADR_PORT, k);
      cyc(2);
      chk({txd_oe, txd_o}, {k[2], k[1]});
    end
    $display("test port done");
    wr(`SCX_ADR_PORT, 32'h6);
    wr(`SCX_ADR_CTRL, 32'h1);
    wr(`SCX_ADR_PORT, 32'h7);
    wr(`SCX_ADR_IRQ_EN, 32'h4);
    rnd = lfsr_next(rnd);
    b = rnd;
    fork
      u_peer.get_async(got);
      begin
        wr(`SCX_ADR_TXBUF, b);
        rd(`SCX_ADR_FLAGS, d);
        chk(d[0], 1'b0);
      end
    join
    chk(got, b);
    n = 0;
    while (irq_out !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk(irq_out, 1'b1);
    rd(`SCX_ADR_FLAGS, d);
    chk(d[0], 1'b1);
    wr(`SCX_ADR_IRQ_EN, 32'h0);
    cyc(2);
    chk(irq_out, 1'b0);
    wr(`SCX_ADR_IRQ_EN, 32'h4);
    cyc(2);
    chk(irq_out, 1'b1);
    wr(`SCX_ADR_IRQ_CLR, 32'h7);
    cyc(2);
    chk(irq_out, 1'b0);
    $display("test transmit done");
    // break: cut a frame after handing the pin to a low port
    rnd = lfsr_next(rnd);
    wr(`SCX_ADR_TXBUF, rnd);
    cyc(3000);
    wr(`SCX_ADR_PORT, 32'h4);
    wr(`SCX_ADR_CTRL, 32'h0);
    rd(`SCX_ADR_FLAGS, d);
    chk(d[0], 1'b1);
    chk({txd_oe, txd_o}, 2'h2);
    wr(`SCX_ADR_PORT, 32'h6);
    wr(`SCX_ADR_CTRL, 32'h1);
    wr(`SCX_ADR_PORT, 32'h7);
    repeat (4) begin
      cyc(500);
      chk(tx_wire, 1'b1);
    end
    $display("test break done");
    wr(`SCX_ADR_CTRL, 32'h3);
    rnd = lfsr_next(rnd);
    b = rnd;
    u_peer.send_async(b);
    cyc(20);
    rd(`SCX_ADR_FLAGS, d);
    chk(d[2], 1'b1);
    rd(`SCX_ADR_RXBUF, d);
    chk(d[7:0], b);
    $display("test receive done");
    wr(`SCX_ADR_PORT, 32'h6);
    wr(`SCX_ADR_IRQ_EN, 32'h0);
    wr(`SCX_ADR_CTRL, 32'h0);
    wr(`SCX_ADR_POWER, 32'h1);
    cyc(10);
    wr(`SCX_ADR_POWER, 32'h0);
    wr(`SCX_ADR_PORT, 32'h7);
    wr(`SCX_ADR_CTRL, 32'h1);
    cyc(3);
    chk({txd_oe, tx_wire}, 2'h3);
    // stop in mid-frame: the character is lost and the line returns high
    rnd = lfsr_next(rnd);
    wr(`SCX_ADR_TXBUF, rnd);
    cyc(1000);
    wr(`SCX_ADR_POWER, 32'h1);
    cyc(10);
    chk(tx_wire, 1'b1);
    wr(`SCX_ADR_POWER, 32'h0);
    repeat (4) begin
      cyc(500);
      chk({txd_oe, tx_wire}, 2'h3);
    end
    $display("test stop done");
    wr(`SCX_ADR_CTRL, 32'h0);
    wr(`SCX_ADR_MODE, 32'h1);
    wr(`SCX_ADR_CTRL, 32'h3);
    wr(`SCX_ADR_IRQ_CLR, 32'h7);
    wr(`SCX_ADR_IRQ_EN, 32'h2);
    rnd = lfsr_next(rnd);
    b = rnd;
    wr(`SCX_ADR_TXBUF, b);
    u_peer.sel(1'b0);
    cyc(20);
    chk(miso_oe, 1'b1);
    u_peer.clk_bits(b, 0, 4);
    u_peer.sel(1'b1);
    cyc(8);
    chk(miso_oe, 1'b0);
    chk(so[7:4], b[3:0]);
    u_peer.clk_bits(b, 4, 8);
    cyc(10);
    chk(irq_out, 1'b1);
    rd(`SCX_ADR_IRQ_STAT, d);
    chk(d[1], 1'b1);
    chk(d[2], 1'b1);
    rd(`SCX_ADR_RXBUF, d);
    chk(d[7:0], b);
    $display("test select done");
    print_verdict;
  end
endmodule
